// [hw/aidiag_pkg.sv]
// Package of constants and types for the analog input diagnostic record.
// Assumes a single 125 MHz clock and a byte-wide record read port.
//
// Contract
// [RULE1] Module class low nibble is analog pattern
// [RULE2] Bit 4 flags channel information present
// [RULE3] Extended bit 3 on diagnostics buffer overflow
// [RULE4] Extended bit 4 on internal communication error
// [RULE5] Extended bit 6 on lost process interrupt
// [RULE6] Channel kind code analog input 71h
// [RULE7] Diagnostic bit count reads eight
// [RULE8] Channel count reads two
// [RULE9] Group error bits 0 and 1
// [RULE10] Channel bit 0 on parameterization error
// [RULE11] Channel bits 1, 2 on raw range
// [RULE12] Channel bit 4 on sensor supply fault
// [RULE13] Channel bit 5 on lost process interrupt
// [RULE14] Channel bits 6, 7 on range under/overflow
// [RULE15] Spare channel error bytes carry no meaning
// [RULE16] Ticker captured into timestamp on event
// [RULE17] Ticker starts zero, wraps after 2^32-1
// [RULE18] Hold diagnostics until cause clears; drop between
// [RULE19] Reserved bits and bytes read zero
// [RULE20] Ticker advances once per microsecond, never pauses
package aidiag_pkg;

  // ----------------------------------------
  // Record byte indices
  // ----------------------------------------
  localparam logic [4:0] AIDIAG_IDX_MODCLS   = 5'h00;
  localparam logic [4:0] AIDIAG_IDX_RSVD     = 5'h01;
  localparam logic [4:0] AIDIAG_IDX_EXTDIAG  = 5'h02;
  localparam logic [4:0] AIDIAG_IDX_CHKIND   = 5'h03;
  localparam logic [4:0] AIDIAG_IDX_NBITS    = 5'h04;
  localparam logic [4:0] AIDIAG_IDX_NCH      = 5'h05;
  localparam logic [4:0] AIDIAG_IDX_GRPERR   = 5'h06;
  localparam logic [4:0] AIDIAG_IDX_CH0      = 5'h07;
  localparam logic [4:0] AIDIAG_IDX_CH1      = 5'h08;
  localparam logic [4:0] AIDIAG_IDX_SPARE0   = 5'h09;
  localparam logic [4:0] AIDIAG_IDX_SPARE5   = 5'h0E;
  localparam logic [4:0] AIDIAG_IDX_TS0      = 5'h0F;
  localparam logic [4:0] AIDIAG_IDX_TS3      = 5'h12;

  // ----------------------------------------
  // Fixed field values
  // ----------------------------------------
  localparam logic [3:0] AIDIAG_CLASS_ANALOG = 4'h5;
  localparam int         AIDIAG_CHINFO_BIT   = 4;
  localparam logic [6:0] AIDIAG_KIND_DIN     = 7'h70;
  localparam logic [6:0] AIDIAG_KIND_AIN     = 7'h71;
  localparam logic [6:0] AIDIAG_KIND_DOUT    = 7'h72;
  localparam logic [6:0] AIDIAG_KIND_AOUT    = 7'h73;
  localparam logic [6:0] AIDIAG_KIND_AIO     = 7'h74;
  localparam logic [6:0] AIDIAG_KIND_CNT     = 7'h76;
  localparam logic [7:0] AIDIAG_NBITS_VAL    = 8'h08;
  localparam logic [7:0] AIDIAG_NCH_VAL      = 8'h02;

  localparam int AIDIAG_EXT_OVF_BIT  = 3;
  localparam int AIDIAG_EXT_COMM_BIT = 4;
  localparam int AIDIAG_EXT_LOST_BIT = 6;

  localparam int AIDIAG_CH_PARAM_BIT = 0;
  localparam int AIDIAG_CH_RAWHI_BIT = 1;
  localparam int AIDIAG_CH_RAWLO_BIT = 2;
  localparam int AIDIAG_CH_SUPP_BIT  = 4;
  localparam int AIDIAG_CH_LOST_BIT  = 5;
  localparam int AIDIAG_CH_UNDR_BIT  = 6;
  localparam int AIDIAG_CH_OVER_BIT  = 7;
  localparam logic [7:0] AIDIAG_CH_MASK = 8'hF7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int AIDIAG_CLK_MHZ = 125;
  localparam int AIDIAG_TICK_NS = 1000;
  localparam int AIDIAG_TICK_CYC = (AIDIAG_TICK_NS * AIDIAG_CLK_MHZ) / 1000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic param_err;
    logic raw_high;
    logic raw_low;
    logic supply_err;
    logic irq_lost;
    logic range_under;
    logic range_over;
  } aidiag_ch_cause_t;

  typedef struct packed {
    logic buf_overflow;
    logic comm_err;
    logic irq_lost;
  } aidiag_mod_cause_t;

endpackage

// [hw/aidiag_ticker.sv]
// Free-running microsecond ticker.
// Assumes one clock at the package rate and a synchronous reset at power-up.
`timescale 1ns/1ps
module aidiag_ticker
  import aidiag_pkg::*;
#(
  parameter int TICK_CYC = AIDIAG_TICK_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst,
  output logic [31:0]      us_count
);

  localparam int PW = $clog2(TICK_CYC + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);

  logic [PW-1:0] pre_r;

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst || pre_r == PRE_LAST) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PW'(1); // RULE20
    end
  end

  // Natural 32-bit wrap returns to zero after the last value
  always_ff @(posedge clock) begin
    if (rst) begin
      us_count <= 32'h0000_0000; // RULE17
    end else if (pre_r == PRE_LAST) begin
      us_count <= us_count + 32'h0000_0001; // RULE17
    end
  end

  property p_tick_step;
    @(posedge clock) disable iff (rst)
      (pre_r == PRE_LAST) |=> (us_count == $past(us_count) + 32'h0000_0001);
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("ticker missed step"); // RULE20

  property p_tick_hold;
    @(posedge clock) disable iff (rst)
      (pre_r != PRE_LAST) |=> $stable(us_count);
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("ticker moved early"); // RULE20

endmodule

// [hw/aidiag_sync.sv]
// Two-stage synchroniser for a bus of level inputs from pins.
// Assumes inputs are asynchronous levels.
`timescale 1ns/1ps
module aidiag_sync #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d_async,
  output logic [W-1:0]      q_sync
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_r <= '0;
      q_sync <= '0;
    end else begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end

endmodule

// [hw/aidiag_record.sv]
// Diagnostic data record of a two-channel analog input module.
// Assumes cause inputs are asynchronous levels from the module's monitors,
// and that the coupler reads one byte per cycle by index.
`timescale 1ns/1ps
module aidiag_record
  import aidiag_pkg::*;
#(
  parameter int       NUM_CH   = 2,
  parameter int       TICK_CYC = AIDIAG_TICK_CYC,
  parameter logic [6:0] KIND   = AIDIAG_KIND_AIN
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  aidiag_ch_cause_t       ch_cause [NUM_CH],
  input  aidiag_mod_cause_t      mod_cause,
  input  wire logic              rd_en,
  input  wire logic [4:0]        rd_index,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   diag_active,
  output logic                   diag_coming,
  output logic                   diag_going,
  output logic [31:0]            diag_timestamp
);

  localparam int CW = $bits(aidiag_ch_cause_t);
  localparam int MW = $bits(aidiag_mod_cause_t);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [NUM_CH*CW-1:0] ch_flat;
  logic [NUM_CH*CW-1:0] ch_sync;
  logic [MW-1:0]        mod_sync;
  aidiag_ch_cause_t     ch_s [NUM_CH];
  aidiag_mod_cause_t    mod_s;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_flat
      assign ch_flat[g*CW +: CW] = ch_cause[g];
      assign ch_s[g]             = ch_sync[g*CW +: CW];
    end
  endgenerate
  assign mod_s = mod_sync;

  aidiag_sync #(.W(NUM_CH*CW)) u_sync_ch (
    .clock   (clock),
    .rst     (rst),
    .d_async (ch_flat),
    .q_sync  (ch_sync)
  );

  aidiag_sync #(.W(MW)) u_sync_mod (
    .clock   (clock),
    .rst     (rst),
    .d_async (mod_cause),
    .q_sync  (mod_sync)
  );

  // ----------------------------------------
  // Microsecond ticker
  // ----------------------------------------
  logic [31:0] us_count;

  aidiag_ticker #(.TICK_CYC(TICK_CYC)) u_ticker (
    .clock    (clock),
    .rst      (rst),
    .us_count (us_count)
  );

  // ----------------------------------------
  // Live cause bytes
  // ----------------------------------------
  logic [7:0] ch_live [NUM_CH];
  logic [7:0] ext_live;
  logic       any_live;

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_live
      always_comb begin
        ch_live[g] = 8'h00;
        ch_live[g][AIDIAG_CH_PARAM_BIT] = ch_s[g].param_err;   // RULE10
        ch_live[g][AIDIAG_CH_RAWHI_BIT] = ch_s[g].raw_high;    // RULE11
        ch_live[g][AIDIAG_CH_RAWLO_BIT] = ch_s[g].raw_low;     // RULE11
        ch_live[g][AIDIAG_CH_SUPP_BIT]  = ch_s[g].supply_err;  // RULE12
        ch_live[g][AIDIAG_CH_LOST_BIT]  = ch_s[g].irq_lost;    // RULE13
        ch_live[g][AIDIAG_CH_UNDR_BIT]  = ch_s[g].range_under; // RULE14
        ch_live[g][AIDIAG_CH_OVER_BIT]  = ch_s[g].range_over;  // RULE14
      end
    end
  endgenerate

  always_comb begin
    ext_live = 8'h00;
    ext_live[AIDIAG_EXT_OVF_BIT]  = mod_s.buf_overflow; // RULE3
    ext_live[AIDIAG_EXT_COMM_BIT] = mod_s.comm_err;     // RULE4
    ext_live[AIDIAG_EXT_LOST_BIT] = mod_s.irq_lost;     // RULE5
  end

  always_comb begin
    any_live = |ext_live;
    for (int i = 0; i < NUM_CH; i++) begin
      any_live = any_live | (|ch_live[i]);
    end
  end

  // ----------------------------------------
  // Coming / going sequencing
  // ----------------------------------------
  typedef enum logic [0:0] {AIDIAG_IDLE, AIDIAG_HELD} aidiag_state_t;
  aidiag_state_t state_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= AIDIAG_IDLE;
    end else begin
      case (state_r)
        AIDIAG_IDLE: begin
          if (any_live) begin
            state_r <= AIDIAG_HELD;
          end
        end
        AIDIAG_HELD: begin
          if (!any_live) begin
            state_r <= AIDIAG_IDLE; // RULE18
          end
        end
        default: state_r <= AIDIAG_IDLE;
      endcase
    end
  end

  logic capture;
  logic release_ev;
  assign capture    = (state_r == AIDIAG_IDLE) && any_live;
  assign release_ev = (state_r == AIDIAG_HELD) && !any_live;

  // ----------------------------------------
  // Held record
  // ----------------------------------------
  // Snapshot taken only on the coming event; later events are dropped
  logic [7:0] ch_hold_r [NUM_CH];
  logic [7:0] ext_hold_r;

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_hold
      always_ff @(posedge clock) begin
        if (rst || release_ev) begin
          ch_hold_r[g] <= 8'h00;
        end else if (capture) begin
          ch_hold_r[g] <= ch_live[g] & AIDIAG_CH_MASK; // RULE18
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst || release_ev) begin
      ext_hold_r <= 8'h00;
    end else if (capture) begin
      ext_hold_r <= ext_live; // RULE18
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      diag_timestamp <= 32'h0000_0000;
    end else if (capture) begin
      diag_timestamp <= us_count; // RULE16
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      diag_coming <= 1'b0;
      diag_going  <= 1'b0;
    end else begin
      diag_coming <= capture;
      diag_going  <= release_ev; // RULE18
    end
  end

  assign diag_active = (state_r == AIDIAG_HELD);

  // ----------------------------------------
  // Derived record bytes
  // ----------------------------------------
  logic [7:0] grp_err;
  logic [7:0] mod_info;
  logic [7:0] kind_byte;

  always_comb begin
    grp_err = 8'h00;
    for (int i = 0; i < NUM_CH && i < 2; i++) begin
      grp_err[i] = |ch_hold_r[i]; // RULE9
    end
  end

  always_comb begin
    mod_info = {4'h0, AIDIAG_CLASS_ANALOG};   // RULE1
    mod_info[AIDIAG_CHINFO_BIT] = 1'b1;       // RULE2
    kind_byte = {1'b0, KIND};                 // RULE6
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00; // RULE19
    case (rd_index)
      AIDIAG_IDX_MODCLS:  rd_mux = mod_info;
      AIDIAG_IDX_EXTDIAG: rd_mux = ext_hold_r;
      AIDIAG_IDX_CHKIND:  rd_mux = kind_byte;
      AIDIAG_IDX_NBITS:   rd_mux = AIDIAG_NBITS_VAL; // RULE7
      AIDIAG_IDX_NCH:     rd_mux = AIDIAG_NCH_VAL;   // RULE8
      AIDIAG_IDX_GRPERR:  rd_mux = grp_err;
      AIDIAG_IDX_CH0:     rd_mux = ch_hold_r[0];
      AIDIAG_IDX_CH1:     rd_mux = ch_hold_r[1];
      default: begin
        if (rd_index >= AIDIAG_IDX_TS0 && rd_index <= AIDIAG_IDX_TS3) begin
          rd_mux = diag_timestamp[8*(rd_index - AIDIAG_IDX_TS0) +: 8]; // RULE16
        end else begin
          rd_mux = 8'h00; // RULE15
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= rd_en ? rd_mux : 8'h00;
      rd_valid <= rd_en;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_cause_rises;
    (state_r == AIDIAG_IDLE) && any_live;
  endsequence

  sequence s_coming_shows;
    diag_coming && (diag_timestamp == $past(us_count));
  endsequence

  property p_capture_stamp;
    @(posedge clock) disable iff (rst) s_cause_rises |=> s_coming_shows;
  endproperty
  a_capture_stamp: assert property (p_capture_stamp) else $error("stamp not captured"); // RULE16

  property p_hold_stable;
    @(posedge clock) disable iff (rst)
      (state_r == AIDIAG_HELD && any_live) |=> $stable(ext_hold_r) && $stable(diag_timestamp);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("held record changed"); // RULE18

  property p_going;
    @(posedge clock) disable iff (rst)
      (state_r == AIDIAG_HELD && !any_live)
        |=> diag_going && (ext_hold_r == 8'h00) && (ch_hold_r[0] == 8'h00);
  endproperty
  a_going: assert property (p_going) else $error("going not signalled"); // RULE18

  property p_read_nbits;
    @(posedge clock) disable iff (rst)
      (rd_en && rd_index == AIDIAG_IDX_NBITS) |=> rd_valid && rd_data == 8'h08;
  endproperty
  a_read_nbits: assert property (p_read_nbits) else $error("bit count wrong"); // RULE7

  property p_read_nch;
    @(posedge clock) disable iff (rst)
      (rd_en && rd_index == AIDIAG_IDX_NCH) |=> rd_data == 8'h02;
  endproperty
  a_read_nch: assert property (p_read_nch) else $error("channel count wrong"); // RULE8

  property p_read_class;
    @(posedge clock) disable iff (rst)
      (rd_en && rd_index == AIDIAG_IDX_MODCLS) |=> rd_data == 8'h15;
  endproperty
  a_read_class: assert property (p_read_class) else $error("module info wrong"); // RULE1

  property p_read_spare;
    @(posedge clock) disable iff (rst)
      (rd_en && rd_index >= AIDIAG_IDX_SPARE0 && rd_index <= AIDIAG_IDX_SPARE5)
        |=> rd_data == 8'h00;
  endproperty
  a_read_spare: assert property (p_read_spare) else $error("spare byte not zero"); // RULE15

  property p_ch_rsvd;
    @(posedge clock) disable iff (rst)
      (ch_hold_r[0][3] == 1'b0) && (ch_hold_r[1][3] == 1'b0) &&
      (ext_hold_r[2:0] == 3'h0) && (ext_hold_r[5] == 1'b0) && (ext_hold_r[7] == 1'b0);
  endproperty
  a_ch_rsvd: assert property (p_ch_rsvd) else $error("reserved bit set"); // RULE19

  // Group bits follow the causes seen at the coming event
  property p_grp;
    @(posedge clock) disable iff (rst)
      s_cause_rises |=> (grp_err[0] == $past(|ch_live[0])) &&
                        (grp_err[1] == $past(|ch_live[1])) && (grp_err[7:2] == 6'h00);
  endproperty
  a_grp: assert property (p_grp) else $error("group error mismatch"); // RULE9

endmodule

// [verification/aidiag_coupler.sv]
// Backplane coupler model that reads the diagnostic record byte by byte.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
module aidiag_coupler (
  input  wire logic  clock,
  output logic       rd_en,
  output logic [4:0] rd_index
);
  initial begin
    rd_en    = 1'b0;
    rd_index = 5'h00;
  end

  // Request held across the sampling edge, changed only after it
  task automatic issue(input logic [4:0] idx);
    rd_en    = 1'b1;
    rd_index = idx;
    @(posedge clock);
    #1;
  endtask

  // Idle index is inverted so a stale index never looks live
  task automatic idle();
    rd_en    = 1'b0;
    rd_index = ~rd_index;
  endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the analog input diagnostic record.
// Assumes the coupler model beside it and a shortened microsecond tick.
`timescale 1ns/1ps
module tb_top import aidiag_pkg::*;;
  localparam int TCYC = 4;

  logic              clock;
  logic              rst;
  aidiag_ch_cause_t  ch_cause [2];
  aidiag_mod_cause_t mod_cause;
  logic              rd_en;
  logic [4:0]        rd_index;
  logic [7:0]        rd_data;
  logic              rd_valid;
  logic              diag_active;
  logic              diag_coming;
  logic              diag_going;
  logic [31:0]       diag_timestamp;
  logic [7:0]        exp_q [$];
  int                fails;
  int                samples_checked;
  int                cyc;
  int                rel;
  int                lo;
  int                seed;
  logic [16:0]       v;
  logic [31:0]       ts;

  aidiag_record #(.TICK_CYC(TCYC)) dut (
    .clock          (clock),
    .rst            (rst),
    .ch_cause       (ch_cause),
    .mod_cause      (mod_cause),
    .rd_en          (rd_en),
    .rd_index       (rd_index),
    .rd_data        (rd_data),
    .rd_valid       (rd_valid),
    .diag_active    (diag_active),
    .diag_coming    (diag_coming),
    .diag_going     (diag_going),
    .diag_timestamp (diag_timestamp)
  );

  aidiag_coupler cpl (
    .clock    (clock),
    .rd_en    (rd_en),
    .rd_index (rd_index)
  );

  initial clock = 1'b0;
  always #4 clock = ~clock;

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_byte({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic complete_run();
    if (exp_q.size() != 0) fails++;
    $display("compared %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [7:0] chmap(input logic [6:0] c);
    return {c[0], c[1], c[2], c[3], 1'b0, c[4], c[5], c[6]};
  endfunction

  function automatic logic [7:0] exp_byte(input logic [4:0] i, input logic [16:0] x,
                                          input logic [31:0] t);
    logic [7:0] c0;
    logic [7:0] c1;
    c0 = chmap(x[16:10]);
    c1 = chmap(x[9:3]);
    case (i)
      AIDIAG_IDX_MODCLS:  return {3'h0, 1'b1, AIDIAG_CLASS_ANALOG};
      AIDIAG_IDX_EXTDIAG: return {1'b0, x[0], 1'b0, x[1], x[2], 3'h0};
      AIDIAG_IDX_CHKIND:  return {1'b0, AIDIAG_KIND_AIN};
      AIDIAG_IDX_NBITS:   return AIDIAG_NBITS_VAL;
      AIDIAG_IDX_NCH:     return AIDIAG_NCH_VAL;
      AIDIAG_IDX_GRPERR:  return {6'h00, |c1, |c0};
      AIDIAG_IDX_CH0:     return c0;
      AIDIAG_IDX_CH1:     return c1;
      5'h0F, 5'h10, 5'h11, 5'h12: return t[8 * (int'(i) - 15) +: 8];
      default:            return 8'h00;
    endcase
  endfunction

  // Oldest note is matched against each answer as it appears
  always @(posedge clock) begin
    if (!rst && rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[ERR] %0t unexpected read answer", $time);
      end else begin
        cmp_byte(rd_data, exp_q.pop_front(), "record byte");
      end
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic set_causes(input logic [16:0] x);
    ch_cause[0] = aidiag_ch_cause_t'(x[16:10]);
    ch_cause[1] = aidiag_ch_cause_t'(x[9:3]);
    mod_cause   = aidiag_mod_cause_t'(x[2:0]);
  endtask

  task automatic read_range(input int a, input int b, input logic [16:0] x,
                            input logic [31:0] t);
    for (int i = a; i <= b; i++) begin
      exp_q.push_back(exp_byte(5'(i), x, t));
      cpl.issue(5'(i));
    end
    cpl.idle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic wait_flag(input bit going);
    for (int n = 0; n < 20; n++) begin
      @(posedge clock);
      #1;
      if ((going ? diag_going : diag_coming) === 1'b1) return;
    end
    fails++;
    $display("[ERR] %0t event flag missing", $time);
  endtask

  initial begin
    rst             = 1'b1;
    seed            = 24;
    fails           = 0;
    samples_checked = 0;
    cyc             = 0;
    set_causes(17'h00000);
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    rel = cyc;
    cmp_bit(diag_active, 1'b0, "active after reset");
    cmp_byte(diag_timestamp[7:0], 8'h00, "stamp after reset");
    read_range(0, 31, 17'h00000, 32'h00000000);
    // One-hot first so every cause bit lands alone, then random mixes
    for (int k = 0; k < 20; k++) begin
      v = (k < 17) ? (17'h00001 << k) : 17'($random(seed));
      if (v == 17'h00000) v = 17'h00001;
      set_causes(v);
      wait_flag(1'b0);
      ts = diag_timestamp;
      lo = (cyc - rel) / TCYC - 2;
      cmp_bit((ts >= 32'(lo)) && (ts <= 32'(lo + 2)), 1'b1, "stamp window");
      cmp_bit(diag_active, 1'b1, "active on coming");
      set_causes(v | 17'($random(seed)));
      repeat (4) @(posedge clock);
      #1;
      read_range(0, 18, v, ts);
      set_causes(17'h00000);
      wait_flag(1'b1);
      cmp_bit(diag_active, 1'b0, "active after going");
      read_range(0, 14, 17'h00000, 32'h00000000);
    end
    complete_run();
  end
endmodule
